// [alcs_regs.svh]
`ifndef ALCS_REGS_SVH
`define ALCS_REGS_SVH
// ----------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------
`define ALCS_IDX_L0_PUMP     16'h1080
`define ALCS_IDX_L0_FBDIV    16'h1081
`define ALCS_IDX_L0_OFFSET   16'h1083
`define ALCS_IDX_L1_PUMP     16'h1480
`define ALCS_IDX_L1_FBDIV    16'h1481
`define ALCS_IDX_L1_OFFSET   16'h1483
`define ALCS_IDX_GLOBAL_CAL  16'h2000
`define ALCS_IDX_L0_EVCLR    16'h200f
`define ALCS_IDX_L1_EVCLR    16'h2014
`define ALCS_IDX_L0_CHAN     16'h2100
`define ALCS_IDX_L1_CHAN     16'h2200
`define ALCS_IDX_L0_EVENTS   16'h3014
`define ALCS_IDX_L1_EVENTS   16'h3019
`define ALCS_IDX_L0_STATUS   16'h3100
`define ALCS_IDX_L1_STATUS   16'h3200
`define ALCS_IDX_PIN_SELECT  16'h3f00
// ----------------------------------------
// field positions
// ----------------------------------------
`define ALCS_BIT_CAL         1
`define ALCS_BIT_MANUAL      7
`define ALCS_BIT_OFS_EN      0
`define ALCS_BIT_OFS_NEG     3
`define ALCS_BIT_LOCK        3
`define ALCS_BIT_BUSY        5
`define ALCS_BIT_DONE        4
`define ALCS_EV_LOCKED       3
`define ALCS_EV_UNLOCKED     2
`define ALCS_EV_STARTED      1
`define ALCS_EV_COMPLETED    0
// ----------------------------------------
// reset values and constants
// ----------------------------------------
`define ALCS_RST_PUMP        8'h90
`define ALCS_RST_FBDIV       8'h01
`define ALCS_RST_OFFSET      8'h03
`define ALCS_AUTO_LIMIT      8'h40
`define ALCS_PUMP_MAX        10'h3f8
`define ALCS_PIN_OFF         2'h0
`define ALCS_PIN_BUSY        2'h1
`define ALCS_PIN_LOCK        2'h2
`endif

// [alcs_pkg.sv]
`default_nettype none
package alcs_pkg;
    typedef struct packed {
        logic [7:0] pump;
        logic [7:0] fbdiv;
        logic [7:0] offset;
        logic [7:0] chan;
        logic [3:0] events;
        logic busy_prev;
        logic done_prev;
        logic lock_prev;
    } alcs_loop_t;
    typedef struct packed {
        alcs_loop_t [1:0] loop;
        logic cal_all;
        logic [1:0] pin_sel;
        logic pin_loop;
        logic [31:0] prdata;
        logic pslverr;
        logic pready;
    } alcs_state_t;
endpackage
`default_nettype wire

// [alcs_top.sv]
// Register access over APB is this design's own decision.
`include "alcs_regs.svh"
`default_nettype none
// Overview of operation
// - per-loop calibrate bit starts that loop's calibration
// - calibrate-all bit calibrates both loops and system
// - status bits 5/4 show live busy and done
// - event bits 1/0 latch started and completed
// - calibration events stay until host clears them
// - busy routable to multipurpose pin
// - 8-bit feedback divider ratio equals value
// - divider value zero means ratio one
// - status bit 3 shows live lock, pin-routable
// - event bits 3/2 latch locked and unlocked
// - lock events stay until host clears them
// - pump bit 7 selects manual or automatic
// - manual current is field times 8 uA
// - automatic current is divider times 16, capped
// - offset bit 0 enables dc offset current
// - offset bit 3 selects negative polarity
// - bits 2:1 pick 50/25/12.5/6.25 percent
// - offset truncated toward zero in 8 uA steps
module alcs_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] core_cal_busy,
    input wire logic [1:0] core_cal_done,
    input wire logic [1:0] core_lock,
    output logic [1:0] core_cal_start,
    output logic system_cal_start,
    output logic [7:0] loop0_fb_ratio,
    output logic [7:0] loop1_fb_ratio,
    output logic [9:0] loop0_pump_current,
    output logic [9:0] loop1_pump_current,
    output logic [9:0] loop0_offset_mag,
    output logic [9:0] loop1_offset_mag,
    output logic [1:0] offset_enable,
    output logic [1:0] offset_negative,
    output logic multipurpose_pin
);
    // ----------------------------------------
    // arithmetic helpers
    // ----------------------------------------
    function automatic logic [7:0] alcs_ratio(input logic [7:0] v);
        alcs_ratio = (v == 8'h00) ? 8'h01 : v;
    endfunction

    function automatic logic [9:0] alcs_pump(input logic [7:0] ctl, input logic [7:0] div);
        logic [7:0] r;
        r = alcs_ratio(div);
        if (ctl[`ALCS_BIT_MANUAL])
            alcs_pump = {ctl[6:0], 3'h0};
        else if (r < `ALCS_AUTO_LIMIT)
            alcs_pump = {r[5:0], 4'h0};
        else
            alcs_pump = `ALCS_PUMP_MAX;
    endfunction

    // magnitude only; sign is separate, so truncation is toward zero
    function automatic logic [9:0] alcs_offset(input logic [7:0] ctl, input logic [9:0] pump_current);
        logic [9:0] f;
        f = pump_current >> (3'h1 + {1'b0, ctl[2:1]});
        alcs_offset = {f[9:3], 3'h0};
    endfunction

    alcs_pkg::alcs_state_t s_q, s_d;
    logic [15:0] idx;
    logic setup, wr_xfer;

    assign idx = paddr[17:2];
    assign setup = psel && !penable;
    // write lands only at the edge where the master sees pready high
    assign wr_xfer = psel && penable && pwrite && pready;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        logic [7:0] rd;
        logic hit;
        logic [7:0] wb;
        logic [3:0] clr;
        logic [3:0] set;
        rd = 8'h00;
        hit = 1'b1;
        wb = pstrb[0] ? pwdata[7:0] : 8'h00;
        clr = 4'h0;
        set = 4'h0;
        s_d = s_q;
        // answer prepared in setup so it stands through the access cycle
        s_d.pready = setup;
        s_d.pslverr = 1'b0;
        unique case (idx)
            `ALCS_IDX_L0_PUMP: rd = s_q.loop[0].pump;
            `ALCS_IDX_L0_FBDIV: rd = s_q.loop[0].fbdiv;
            `ALCS_IDX_L0_OFFSET: rd = s_q.loop[0].offset;
            `ALCS_IDX_L1_PUMP: rd = s_q.loop[1].pump;
            `ALCS_IDX_L1_FBDIV: rd = s_q.loop[1].fbdiv;
            `ALCS_IDX_L1_OFFSET: rd = s_q.loop[1].offset;
            `ALCS_IDX_GLOBAL_CAL: rd = {6'h00, s_q.cal_all, 1'b0};
            `ALCS_IDX_L0_EVCLR: rd = 8'h00;
            `ALCS_IDX_L1_EVCLR: rd = 8'h00;
            `ALCS_IDX_L0_CHAN: rd = s_q.loop[0].chan;
            `ALCS_IDX_L1_CHAN: rd = s_q.loop[1].chan;
            `ALCS_IDX_L0_EVENTS: rd = {4'h0, s_q.loop[0].events};
            `ALCS_IDX_L1_EVENTS: rd = {4'h0, s_q.loop[1].events};
            `ALCS_IDX_L0_STATUS: rd = {2'h0, core_cal_busy[0], core_cal_done[0],
                                       core_lock[0], 3'h0};
            `ALCS_IDX_L1_STATUS: rd = {2'h0, core_cal_busy[1], core_cal_done[1],
                                       core_lock[1], 3'h0};
            `ALCS_IDX_PIN_SELECT: rd = {5'h00, s_q.pin_loop, s_q.pin_sel};
            default: hit = 1'b0;
        endcase
        if (setup)
        begin
            s_d.pslverr = !hit;
            if (!pwrite)
                s_d.prdata = {24'h00_0000, rd};
        end
        if (wr_xfer)
        begin
            if (pstrb[0])
            begin
                unique case (idx)
                    `ALCS_IDX_L0_PUMP: s_d.loop[0].pump = wb;
                    `ALCS_IDX_L0_FBDIV: s_d.loop[0].fbdiv = wb;
                    `ALCS_IDX_L0_OFFSET: s_d.loop[0].offset = {4'h0, wb[3:0]};
                    `ALCS_IDX_L1_PUMP: s_d.loop[1].pump = wb;
                    `ALCS_IDX_L1_FBDIV: s_d.loop[1].fbdiv = wb;
                    `ALCS_IDX_L1_OFFSET: s_d.loop[1].offset = {4'h0, wb[3:0]};
                    `ALCS_IDX_GLOBAL_CAL: s_d.cal_all = wb[`ALCS_BIT_CAL];
                    `ALCS_IDX_L0_EVCLR: clr = wb[3:0];
                    `ALCS_IDX_L0_CHAN: s_d.loop[0].chan = wb;
                    `ALCS_IDX_L1_CHAN: s_d.loop[1].chan = wb;
                    `ALCS_IDX_PIN_SELECT:
                    begin
                        s_d.pin_sel = wb[1:0];
                        s_d.pin_loop = wb[2];
                    end
                    default: ;
                endcase
            end
        end
        for (int i = 0; i < 2; i++)
        begin
            logic [3:0] c;
            c = 4'h0;
            if (wr_xfer && pstrb[0] && (i == 1) && (idx == `ALCS_IDX_L1_EVCLR))
                c = wb[3:0];
            else if (i == 0)
                c = clr;
            // edge detect on core levels; set beats same-cycle clear
            set[`ALCS_EV_STARTED] = core_cal_busy[i] && !s_q.loop[i].busy_prev;
            set[`ALCS_EV_COMPLETED] = core_cal_done[i] && !s_q.loop[i].done_prev;
            set[`ALCS_EV_LOCKED] = core_lock[i] && !s_q.loop[i].lock_prev;
            set[`ALCS_EV_UNLOCKED] = !core_lock[i] && s_q.loop[i].lock_prev;
            s_d.loop[i].events = (s_q.loop[i].events & ~c) | set;
            s_d.loop[i].busy_prev = core_cal_busy[i];
            s_d.loop[i].done_prev = core_cal_done[i];
            s_d.loop[i].lock_prev = core_lock[i];
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 2; i++)
            begin
                s_q.loop[i].pump <= `ALCS_RST_PUMP;
                s_q.loop[i].fbdiv <= `ALCS_RST_FBDIV;
                s_q.loop[i].offset <= `ALCS_RST_OFFSET;
                s_q.loop[i].chan <= 8'h00;
                s_q.loop[i].events <= 4'h0;
                s_q.loop[i].busy_prev <= 1'b0;
                s_q.loop[i].done_prev <= 1'b0;
                s_q.loop[i].lock_prev <= 1'b0;
            end
            s_q.cal_all <= 1'b0;
            s_q.pin_sel <= `ALCS_PIN_OFF;
            s_q.pin_loop <= 1'b0;
            s_q.prdata <= 32'h0000_0000;
            s_q.pslverr <= 1'b0;
            s_q.pready <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // level calibrate request; the core starts on its rising edge
    assign core_cal_start[0] = s_q.loop[0].chan[`ALCS_BIT_CAL] | s_q.cal_all;
    assign core_cal_start[1] = s_q.loop[1].chan[`ALCS_BIT_CAL] | s_q.cal_all;
    assign system_cal_start = s_q.cal_all;
    assign loop0_fb_ratio = alcs_ratio(s_q.loop[0].fbdiv);
    assign loop1_fb_ratio = alcs_ratio(s_q.loop[1].fbdiv);
    assign loop0_pump_current = alcs_pump(s_q.loop[0].pump, s_q.loop[0].fbdiv);
    assign loop1_pump_current = alcs_pump(s_q.loop[1].pump, s_q.loop[1].fbdiv);
    assign loop0_offset_mag = alcs_offset(s_q.loop[0].offset, loop0_pump_current);
    assign loop1_offset_mag = alcs_offset(s_q.loop[1].offset, loop1_pump_current);
    assign offset_enable[0] = s_q.loop[0].offset[`ALCS_BIT_OFS_EN];
    assign offset_enable[1] = s_q.loop[1].offset[`ALCS_BIT_OFS_EN];
    assign offset_negative[0] = s_q.loop[0].offset[`ALCS_BIT_OFS_NEG];
    assign offset_negative[1] = s_q.loop[1].offset[`ALCS_BIT_OFS_NEG];
    assign multipurpose_pin = (s_q.pin_sel == `ALCS_PIN_BUSY) ? core_cal_busy[s_q.pin_loop] :
                              (s_q.pin_sel == `ALCS_PIN_LOCK) ? core_lock[s_q.pin_loop] :
                              1'b0;
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
endmodule
`default_nettype wire

// [alcs_core_model.sv]
`default_nettype none
// ----------------------------------------
// analog loop core stand-in
// ----------------------------------------
module alcs_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] cal_start,
    input wire logic [1:0] unlock,
    input wire logic slow,
    output logic [1:0] busy,
    output logic [1:0] done,
    output logic [1:0] lock
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt [2];
    logic [1:0] start_q;
    // lock only after a finished band search; unlock lets the bench drop it
    assign lock = done & ~unlock;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            start_q <= 2'b00;
            busy <= 2'b00;
            done <= 2'b00;
            cnt <= '{0, 0};
        end
        else
        begin
            start_q <= cal_start;
            for (int i = 0; i < 2; i++)
            begin
                if (cal_start[i] && !start_q[i])
                begin
                    cnt[i] <= slow ? 12 : 2;
                    busy[i] <= 1'b1;
                    done[i] <= 1'b0;
                end
                else if (cnt[i] == 1)
                begin
                    cnt[i] <= 0;
                    busy[i] <= 1'b0;
                    done[i] <= 1'b1;
                end
                else if (cnt[i] > 1)
                    cnt[i] <= cnt[i] - 1;
            end
        end
    end
endmodule
`default_nettype wire

// [alcs_checker_asserts.sv]
`include "alcs_regs.svh"
`default_nettype none
module alcs_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] core_cal_start,
    input wire logic system_cal_start,
    input wire logic [7:0] loop0_fb_ratio,
    input wire logic [9:0] loop0_pump_current,
    input wire logic [9:0] loop0_offset_mag
);
    // ----------------------------------------
    // port relations
    // ----------------------------------------
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    fb_ratio_a: assert property (loop0_fb_ratio != 8'h00) else $error("ratio zero");
    pump_step_a: assert property (
        loop0_pump_current[2:0] == 3'h0 && loop0_pump_current <= 10'h3f8)
        else $error("pump current off step");
    offset_step_a: assert property (
        loop0_offset_mag[2:0] == 3'h0 && loop0_offset_mag <= loop0_pump_current / 2)
        else $error("offset magnitude off step");
    cal_start_a: assert property (
        psel && penable && pready && pwrite && pstrb[0] && pwdata[1]
        && paddr[17:2] == `ALCS_IDX_L0_CHAN |=> core_cal_start[0]) else $error("no cal start");
    global_cal_a: assert property (
        psel && penable && pready && pwrite && pstrb[0] && pwdata[1]
        && paddr[17:2] == `ALCS_IDX_GLOBAL_CAL |=> system_cal_start && core_cal_start == 2'b11)
        else $error("global cal missing");
    unmapped_err_a: assert property (psel && penable && paddr[17:2] == 16'h0004
        |-> pslverr && pready) else $error("no error on unmapped");
    access_ready_a: assert property (psel && penable |-> pready) else $error("wait state");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
    read_upper_a: assert property (prdata[31:8] == 24'h00_0000) else $error("upper bits set");
    cover property (core_cal_start[0]);
    cover property (system_cal_start);
    cover property (pslverr);
endmodule
bind alcs_top alcs_checker u_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_cal_start(core_cal_start),
    .system_cal_start(system_cal_start), .loop0_fb_ratio(loop0_fb_ratio),
    .loop0_pump_current(loop0_pump_current), .loop0_offset_mag(loop0_offset_mag));
`default_nettype wire

// [analog_loop_control_status_tb.sv]
`include "alcs_regs.svh"
`default_nettype none
module analog_loop_control_status_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
    logic [17:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, seed = 32'h0000_f7a7;
    logic pready, pslverr, err, sys_start, mpin;
    logic [1:0] busy, done, lock, start, oen, oneg, unlock = 2'b00;
    logic [7:0] fb0, fb1;
    logic [9:0] pc0, pc1, om0, om1;
    int errors = 0, checks = 0, cyc = 0, l;
    int pump [2] = '{144, 144}, div [2] = '{1, 1}, ofr [2] = '{3, 3};
    alcs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .core_cal_busy(busy), .core_cal_done(done),
        .core_lock(lock), .core_cal_start(start), .system_cal_start(sys_start),
        .loop0_fb_ratio(fb0), .loop1_fb_ratio(fb1), .loop0_pump_current(pc0),
        .loop1_pump_current(pc1), .loop0_offset_mag(om0), .loop1_offset_mag(om1),
        .offset_enable(oen), .offset_negative(oneg), .multipurpose_pin(mpin));
    alcs_core_model core (.pclk(pclk), .presetn(presetn), .cal_start(start), .unlock(unlock),
        .slow(slow), .busy(busy), .done(done), .lock(lock));
    initial forever #12.5 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            summarize();
        end
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int pump_current(int k);
        int r = div[k] == 0 ? 1 : div[k];
        return pump[k][7] ? (pump[k] & 127) * 8 : (r < 64 ? r * 16 : 1016);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // zero wait states expected, but waits on pready anyway
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic outs(int k);
        chk(k ? fb1 : fb0, div[k] == 0 ? 1 : div[k]);
        chk(k ? pc1 : pc0, pump_current(k));
        chk(k ? om1 : om0, (pump_current(k) >> (((ofr[k] >> 1) & 3) + 1)) / 8 * 8);
        chk({oen[k], oneg[k]}, {ofr[k][0], ofr[k][3]});
    endtask
    task automatic summarize();
        if (errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(pc0, 32'h0000_0080);
        chk(mpin, 1'b0);
        for (int n = 0; n < 50; n++)
        begin
            l = n % 2;
            if (n > 1)
            begin
                pump[l] = rnd() & 255;
                div[l] = n == 6 ? 0 : rnd() & (n % 3 ? 255 : 63);
                ofr[l] = rnd() & 15;
                apb(1, `ALCS_IDX_L0_PUMP + l * 1024, pump[l]);
                apb(1, `ALCS_IDX_L0_FBDIV + l * 1024, div[l]);
                apb(1, `ALCS_IDX_L0_OFFSET + l * 1024, ofr[l] | 240);
            end
            apb(0, `ALCS_IDX_L0_OFFSET + l * 1024, 0);
            chk(rd, ofr[l]);
            outs(l);
        end
        for (l = 0; l < 2; l++)
        begin
            slow <= l[0];
            apb(1, `ALCS_IDX_PIN_SELECT, l * 4 + 1);
            apb(1, `ALCS_IDX_L0_CHAN + l * 256, 8'h02);
            apb(1, `ALCS_IDX_L0_CHAN + l * 256, 8'h00);
            if (l)
                chk(mpin, 1'b1);
            for (int k = 0; k < 100 && done[l] !== 1'b1; k++) @(posedge pclk);
            apb(0, `ALCS_IDX_L0_STATUS + l * 256, 0);
            chk(rd, 32'h0000_0018);
            apb(0, `ALCS_IDX_L0_EVENTS + l * 5, 0);
            chk(rd, 32'h0000_000b);
            apb(0, `ALCS_IDX_L1_EVENTS - l * 5, 0);
            chk(rd, 32'h0000_0000);
            apb(1, `ALCS_IDX_PIN_SELECT, l * 4 + 2);
            @(posedge pclk);
            chk(mpin, 1'b1);
            apb(1, `ALCS_IDX_L0_EVCLR + l * 5, 8'h0f);
            apb(0, `ALCS_IDX_L0_EVENTS + l * 5, 0);
            chk(rd, 32'h0000_0000);
            unlock[l] <= 1'b1;
            repeat (2) @(posedge pclk);
            chk(mpin, 1'b0);
            apb(0, `ALCS_IDX_L0_EVENTS + l * 5, 0);
            chk(rd, 32'h0000_0004);
            apb(1, `ALCS_IDX_L0_EVCLR + l * 5, 8'h0f);
        end
        apb(1, `ALCS_IDX_GLOBAL_CAL, 8'h02);
        @(posedge pclk);
        chk({sys_start, start}, 3'b111);
        apb(1, `ALCS_IDX_GLOBAL_CAL, 8'h00);
        @(posedge pclk);
        chk({sys_start, start}, 3'b000);
        for (int k = 0; k < 100 && done !== 2'b11; k++) @(posedge pclk);
        for (l = 0; l < 2; l++)
        begin
            apb(0, `ALCS_IDX_L0_EVENTS + l * 5, 0);
            chk(rd, 32'h0000_0003);
        end
        apb(0, 16'h0004, 0);
        chk(err, 1'b1);
        summarize();
    end
endmodule
`default_nettype wire
